// ### hdl/repeater_port_control_states.sv
// Contract
// - each port holds its own transmit state; new ones accepted any time
// - Idle_Up on cascade while controlling hands control upward
// - Idle_Up on cascade while not controlling means no traffic
// - Idle_Down on a local port means nothing for that lower entity
// - Incoming goes out on local ports only
// - Grant on local ports only; end node gets one packet
// - lower repeater grant covers a full round-robin cycle
// - Enable_High_Only reclaims control, only toward lower repeaters
// - requests on cascade only; high if any high, else normal
// - Return on cascade asks control back after interrupted normal cycle
// - Training_Up on cascade, Training_Down on local ports
// - any port may be asked to disable its transmitters
// - receive state is current with grant zero, previous with grant one
// - Idle_Up at local port: no traffic, or control handed up
// - Idle_Down at cascade: upper repeater has no traffic
// - Incoming recognised only at the cascade port
// - Enable_High_Only recognised only at cascade: upper wants control
// - Return recognised only at local ports, as grant state one
// - cascade grant after request: continuing if controlling, else new cycle
// - grant one after Enable_High_Only: control returned to finish cycle
// - Training_Up at local, Training_Down at cascade interpreted
`timescale 1ns/1ps
`default_nettype none
module repeater_port_control_states #(
  parameter int NUM_LOCAL_PORTS = rpc_pkg::DEF_LOCAL_PORTS
) (
  input  wire logic                                   core_clk_in,
  input  wire logic                                   reset_n_in,
  input  wire logic                                   ctrl_net_in,
  input  wire logic                                   casc_pass_up_in,
  input  wire logic                                   casc_high_pend_in,
  input  wire logic                                   casc_norm_pend_in,
  input  wire logic                                   casc_interrupted_in,
  input  wire logic                                   casc_train_req_in,
  input  wire logic                                   casc_tx_off_in,
  input  wire logic          [NUM_LOCAL_PORTS:0]      loc_cmd_valid_in,
  input  wire rpc_pkg::tcs_t [NUM_LOCAL_PORTS:0]      loc_cmd_in,
  input  wire logic          [NUM_LOCAL_PORTS:0]      lower_rep_in,
  input  wire rpc_pkg::rcs_t [NUM_LOCAL_PORTS:0]      rcs_in,
  input  wire logic          [NUM_LOCAL_PORTS:0]      grant_state_in,
  output logic               [NUM_LOCAL_PORTS:0][10:0] tcs_out,
  output logic               [NUM_LOCAL_PORTS:0]      tcs_upd_out,
  output logic               [NUM_LOCAL_PORTS:0]      cmd_reject_out,
  output logic               [NUM_LOCAL_PORTS:0][3:0] rcs_cur_out,
  output logic               [NUM_LOCAL_PORTS:0]      data_on_link_out,
  output logic               [NUM_LOCAL_PORTS:0]      link_warn_out,
  output logic               [NUM_LOCAL_PORTS:0]      mode_trans_out,
  output logic               [NUM_LOCAL_PORTS:0]      req_high_out,
  output logic               [NUM_LOCAL_PORTS:0]      req_norm_out,
  output logic               [NUM_LOCAL_PORTS:0]      no_traffic_out,
  output logic               [NUM_LOCAL_PORTS:0]      ctl_up_out,
  output logic               [NUM_LOCAL_PORTS:0]      return_out,
  output logic               [NUM_LOCAL_PORTS:0]      ctl_back_out,
  output logic               [NUM_LOCAL_PORTS:0]      train_req_out,
  output logic               [NUM_LOCAL_PORTS:0]      grant_used_out,
  output logic                                        pass_up_out,
  output logic                                        up_idle_out,
  output logic                                        up_incoming_out,
  output logic                                        up_en_high_out,
  output logic                                        up_train_ok_out,
  output logic                                        cont_grant_out,
  output logic                                        cycle_grant_out
);
  import rpc_pkg::*;

  logic [RST_STAGES-1:0] rst_sync_q;
  logic                  rst_n;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[RST_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[RST_STAGES-1];

  // cascade port: one state chosen from the central machines' wishes
  tcs_t casc_want;
  logic casc_valid;
  tcs_t casc_tcs;

  always_comb begin
    if (casc_tx_off_in) begin
      casc_want = TCS_TX_OFF;
    end else if (casc_train_req_in) begin
      casc_want = TCS_TRAIN_UP;
    end else if (casc_pass_up_in && ctrl_net_in) begin
      casc_want = TCS_IDLE_UP;
    end else if (casc_high_pend_in) begin
      casc_want = TCS_REQ_HIGH;
    end else if (casc_interrupted_in && casc_norm_pend_in && !ctrl_net_in) begin
      casc_want = TCS_RETURN;
    end else if (casc_norm_pend_in) begin
      casc_want = TCS_REQ_NORM;
    end else begin
      casc_want = TCS_IDLE_UP;
    end
    // only reissue on change so the update strobe marks real transitions
    casc_valid = (casc_want != casc_tcs);
  end

  logic pass_up_d, pass_up_q;
  logic up_idle_d, up_idle_q;
  logic up_inc_d, up_inc_q;
  logic up_eh_d, up_eh_q;
  logic up_tr_d, up_tr_q;
  logic cont_d, cont_q;
  logic cyc_d, cyc_q;

  genvar p;
  generate
    for (p = 0; p <= NUM_LOCAL_PORTS; p++) begin : g_port
      port_ctl_if pif ();

      tx_state_hold #(
        .IS_CASCADE (p == CASCADE_PORT)
      ) u_tx (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n),
        .port        (pif.tx)
      );

      rx_state_decode u_rx (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n),
        .port        (pif.rx)
      );

      assign pif.rcs = rcs_in[p];
      assign pif.gs  = grant_state_in[p];

      assign tcs_out[p]          = pif.tcs;
      assign tcs_upd_out[p]      = pif.tcs_upd;
      assign cmd_reject_out[p]   = pif.reject;
      assign rcs_cur_out[p]      = pif.rcs_cur;
      // link condition decodes, registered from the next receive value
      // so the outputs come from flops yet stay in step with rcs_cur_out
      rcs_t rcs_nx;
      logic dol_d, dol_q, lw_d, lw_q, mt_d, mt_q;

      always_comb begin
        rcs_nx = pif.gs ? pif.rcs_cur : pif.rcs;
        dol_d  = (rcs_nx == RCS_DATA);
        lw_d   = (rcs_nx == RCS_LINK_WARN);
        mt_d   = (rcs_nx == RCS_MODE_TRANS);
      end

      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          dol_q <= 1'b0;
          lw_q  <= 1'b0;
          mt_q  <= 1'b0;
        end else begin
          dol_q <= dol_d;
          lw_q  <= lw_d;
          mt_q  <= mt_d;
        end
      end

      assign data_on_link_out[p] = dol_q;
      assign link_warn_out[p]    = lw_q;
      assign mode_trans_out[p]   = mt_q;

      if (p == CASCADE_PORT) begin : g_casc
        assign pif.cmd_valid = casc_valid;
        assign pif.cmd       = casc_want;
        assign pif.lower_rep = 1'b0;
        assign casc_tcs      = pif.tcs;

        always_comb begin
          pass_up_d = (pif.tcs == TCS_IDLE_UP) && ctrl_net_in;
          up_idle_d = (pif.rcs_cur == RCS_IDLE_DOWN);
          up_inc_d  = (pif.rcs_cur == RCS_INCOMING);
          up_eh_d   = (pif.rcs_cur == RCS_EN_HIGH);
          up_tr_d   = (pif.rcs_cur == RCS_TRAIN_DOWN);
          cont_d    = 1'b0;
          cyc_d     = 1'b0;
          if (pif.gs_edge && (pif.tcs == TCS_REQ_HIGH || pif.tcs == TCS_REQ_NORM)) begin
            cont_d = ctrl_net_in;
            cyc_d  = !ctrl_net_in;
          end
        end

        always_ff @(posedge core_clk_in or negedge rst_n) begin
          if (!rst_n) begin
            pass_up_q <= 1'b0;
            up_idle_q <= 1'b0;
            up_inc_q  <= 1'b0;
            up_eh_q   <= 1'b0;
            up_tr_q   <= 1'b0;
            cont_q    <= 1'b0;
            cyc_q     <= 1'b0;
          end else begin
            pass_up_q <= pass_up_d;
            up_idle_q <= up_idle_d;
            up_inc_q  <= up_inc_d;
            up_eh_q   <= up_eh_d;
            up_tr_q   <= up_tr_d;
            cont_q    <= cont_d;
            cyc_q     <= cyc_d;
          end
        end

        // local-only meanings do not exist on the cascade port
        assign req_high_out[p]   = 1'b0;
        assign req_norm_out[p]   = 1'b0;
        assign no_traffic_out[p] = 1'b0;
        assign ctl_up_out[p]     = 1'b0;
        assign return_out[p]     = 1'b0;
        assign ctl_back_out[p]   = 1'b0;
        assign train_req_out[p]  = 1'b0;
        assign grant_used_out[p] = 1'b0;
      end else begin : g_local
        grant_state_t gr_d, gr_q;
        logic         done;
        logic         rh_d, rh_q, rn_d, rn_q, nt_d, nt_q, cu_d, cu_q;
        logic         rt_d, rt_q, cb_d, cb_q, tr_d, tr_q, gu_d, gu_q;

        always_comb begin
          gr_d = gr_q;
          done = 1'b0;
          unique case (gr_q)
            GR_IDLE: begin
              if (pif.tcs_upd && pif.tcs == TCS_GRANT && !lower_rep_in[p]) begin
                gr_d = GR_WAIT;
              end
            end
            GR_WAIT: begin
              if (pif.tcs != TCS_GRANT) begin
                gr_d = GR_IDLE;
              end else if (pif.rcs_cur == RCS_DATA) begin
                gr_d = GR_DATA;
              end
            end
            GR_DATA: begin
              // end node's single packet over: withdraw the grant
              if (pif.rcs_cur != RCS_DATA) begin
                gr_d = GR_IDLE;
                done = (pif.tcs == TCS_GRANT);
              end
            end
            default: gr_d = GR_IDLE;
          endcase
          // a lower repeater keeps its grant until the central machines move on
          rh_d = (pif.rcs_cur == RCS_REQ_HIGH);
          rn_d = (pif.rcs_cur == RCS_REQ_NORM);
          nt_d = (pif.rcs_cur == RCS_IDLE_UP);
          cu_d = nt_d && lower_rep_in[p] && (pif.tcs == TCS_GRANT);
          rt_d = pif.gs_edge && lower_rep_in[p] && (pif.tcs != TCS_EN_HIGH);
          cb_d = pif.gs_edge && lower_rep_in[p] && (pif.tcs == TCS_EN_HIGH) && ctrl_net_in;
          tr_d = (pif.rcs_cur == RCS_TRAIN_UP);
          gu_d = done;
        end

        always_ff @(posedge core_clk_in or negedge rst_n) begin
          if (!rst_n) begin
            gr_q <= GR_IDLE;
            rh_q <= 1'b0;
            rn_q <= 1'b0;
            nt_q <= 1'b0;
            cu_q <= 1'b0;
            rt_q <= 1'b0;
            cb_q <= 1'b0;
            tr_q <= 1'b0;
            gu_q <= 1'b0;
          end else begin
            gr_q <= gr_d;
            rh_q <= rh_d;
            rn_q <= rn_d;
            nt_q <= nt_d;
            cu_q <= cu_d;
            rt_q <= rt_d;
            cb_q <= cb_d;
            tr_q <= tr_d;
            gu_q <= gu_d;
          end
        end

        // central command wins over the automatic release of a used grant
        assign pif.cmd_valid = loc_cmd_valid_in[p] || done;
        assign pif.cmd       = loc_cmd_valid_in[p] ? loc_cmd_in[p] : TCS_IDLE_DOWN;
        assign pif.lower_rep = lower_rep_in[p];

        assign req_high_out[p]   = rh_q;
        assign req_norm_out[p]   = rn_q;
        assign no_traffic_out[p] = nt_q;
        assign ctl_up_out[p]     = cu_q;
        assign return_out[p]     = rt_q;
        assign ctl_back_out[p]   = cb_q;
        assign train_req_out[p]  = tr_q;
        assign grant_used_out[p] = gu_q;
      end
    end
  endgenerate

  assign pass_up_out     = pass_up_q;
  assign up_idle_out     = up_idle_q;
  assign up_incoming_out = up_inc_q;
  assign up_en_high_out  = up_eh_q;
  assign up_train_ok_out = up_tr_q;
  assign cont_grant_out  = cont_q;
  assign cycle_grant_out = cyc_q;
endmodule : repeater_port_control_states
`default_nettype wire

// ### hdl/rpc_pkg.sv
package rpc_pkg;

  localparam int DEF_LOCAL_PORTS = 100;
  localparam int CASCADE_PORT    = 0;
  localparam int TCS_W           = 11;
  localparam int RCS_W           = 4;
  localparam int RST_STAGES      = 2;

  // one code per transmit control state, held for the PMI
  typedef enum logic [TCS_W-1:0] {
    TCS_IDLE_UP    = 11'h001,
    TCS_IDLE_DOWN  = 11'h002,
    TCS_INCOMING   = 11'h004,
    TCS_GRANT      = 11'h008,
    TCS_EN_HIGH    = 11'h010,
    TCS_REQ_HIGH   = 11'h020,
    TCS_REQ_NORM   = 11'h040,
    TCS_RETURN     = 11'h080,
    TCS_TRAIN_UP   = 11'h100,
    TCS_TRAIN_DOWN = 11'h200,
    TCS_TX_OFF     = 11'h400
  } tcs_t;

  typedef enum logic [RCS_W-1:0] {
    RCS_DATA       = 4'h0,
    RCS_IDLE_UP    = 4'h1,
    RCS_IDLE_DOWN  = 4'h2,
    RCS_INCOMING   = 4'h3,
    RCS_LINK_WARN  = 4'h4,
    RCS_MODE_TRANS = 4'h5,
    RCS_EN_HIGH    = 4'h6,
    RCS_REQ_HIGH   = 4'h7,
    RCS_REQ_NORM   = 4'h8,
    RCS_TRAIN_UP   = 4'h9,
    RCS_TRAIN_DOWN = 4'ha
  } rcs_t;

  typedef enum logic [2:0] {
    GR_IDLE = 3'h1,
    GR_WAIT = 3'h2,
    GR_DATA = 3'h4
  } grant_state_t;

  localparam tcs_t TCS_CASC_RST  = TCS_IDLE_UP;
  localparam tcs_t TCS_LOCAL_RST = TCS_IDLE_DOWN;
  localparam rcs_t RCS_RST       = RCS_IDLE_UP;

  // which states a port of the given role may carry
  function automatic logic tcs_legal(input tcs_t c, input logic casc, input logic lower);
    logic ok;
    ok = 1'b0;
    case (c)
      TCS_IDLE_UP, TCS_REQ_HIGH, TCS_REQ_NORM, TCS_RETURN, TCS_TRAIN_UP: ok = casc;
      TCS_IDLE_DOWN, TCS_INCOMING, TCS_GRANT, TCS_TRAIN_DOWN:            ok = !casc;
      TCS_EN_HIGH:                                                       ok = !casc && lower;
      TCS_TX_OFF:                                                        ok = 1'b1;
      default:                                                           ok = 1'b0;
    endcase
    return ok;
  endfunction : tcs_legal

endpackage : rpc_pkg

// ### hdl/port_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface port_ctl_if;
  import rpc_pkg::*;
  logic cmd_valid;
  tcs_t cmd;
  logic lower_rep;
  tcs_t tcs;
  logic tcs_upd;
  logic reject;
  rcs_t rcs;
  logic gs;
  rcs_t rcs_cur;
  logic gs_edge;

  modport tx (input cmd_valid, cmd, lower_rep, output tcs, tcs_upd, reject);
  modport rx (input rcs, gs, output rcs_cur, gs_edge);
  modport ctl (output cmd_valid, cmd, lower_rep, rcs, gs,
               input tcs, tcs_upd, reject, rcs_cur, gs_edge);
endinterface : port_ctl_if
`default_nettype wire

// ### hdl/tx_state_hold.sv
`timescale 1ns/1ps
`default_nettype none
module tx_state_hold #(
  parameter bit IS_CASCADE = 1'b0
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  port_ctl_if.tx   port
);
  import rpc_pkg::*;

  tcs_t tcs_d, tcs_q;
  logic upd_d, upd_q;
  logic rej_d, rej_q;
  logic legal;

  always_comb begin
    legal = tcs_legal(port.cmd, IS_CASCADE, port.lower_rep);
    tcs_d = tcs_q;
    upd_d = 1'b0;
    rej_d = 1'b0;
    // accepted at any time, independent of other ports and of buffer activity
    if (port.cmd_valid && legal) begin
      tcs_d = port.cmd;
      upd_d = 1'b1;
    end else if (port.cmd_valid) begin
      rej_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tcs_q <= IS_CASCADE ? TCS_CASC_RST : TCS_LOCAL_RST;
      upd_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      tcs_q <= tcs_d;
      upd_q <= upd_d;
      rej_q <= rej_d;
    end
  end

  assign port.tcs     = tcs_q;
  assign port.tcs_upd = upd_q;
  assign port.reject  = rej_q;
endmodule : tx_state_hold
`default_nettype wire

// ### hdl/rx_state_decode.sv
`timescale 1ns/1ps
`default_nettype none
module rx_state_decode (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  port_ctl_if.rx   port
);
  import rpc_pkg::*;

  rcs_t rcs_d, rcs_q;
  logic gs_q;
  logic edge_d, edge_q;

  always_comb begin
    // with grant set the reported state is the previous one, so keep ours
    rcs_d  = port.gs ? rcs_q : port.rcs;
    edge_d = port.gs && !gs_q;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rcs_q  <= RCS_RST;
      gs_q   <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      rcs_q  <= rcs_d;
      gs_q   <= port.gs;
      edge_q <= edge_d;
    end
  end

  assign port.rcs_cur = rcs_q;
  assign port.gs_edge = edge_q;
endmodule : rx_state_decode
`default_nettype wire

// ### verif/rpc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rpc_asserts #(
  parameter int N = 3
) (
  input wire logic                core_clk_in,
  input wire logic                reset_n_in,
  input wire logic                ctrl_net_in,
  input wire logic                casc_pass_up_in,
  input wire logic                casc_high_pend_in,
  input wire logic                casc_train_req_in,
  input wire logic                casc_tx_off_in,
  input wire logic [N:0]          loc_cmd_valid_in,
  input wire rpc_pkg::tcs_t [N:0] loc_cmd_in,
  input wire logic [N:0]          lower_rep_in,
  input wire logic [N:0]          grant_state_in,
  input wire logic [N:0][10:0]    tcs_out,
  input wire logic [N:0]          cmd_reject_out,
  input wire logic [N:0][3:0]     rcs_cur_out,
  input wire logic                cycle_grant_out
);
  import rpc_pkg::*;
  logic [1:0] rc_q;
  logic [1:0] rc_d;
  logic       rdy;
  // internal reset trails the pin by two edges, so checks wait
  always_comb rc_d = (rc_q == 2'h3) ? rc_q : rc_q + 2'h1;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) rc_q <= 2'h0;
    else rc_q <= rc_d;
  end
  assign rdy = (rc_q == 2'h3);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  property p_off;
    rdy && casc_tx_off_in |=> tcs_out[0] == TCS_TX_OFF;
  endproperty
  a_off: assert property (p_off) else $error("cascade tx off missing");
  property p_high;
    rdy && casc_high_pend_in && !casc_tx_off_in && !casc_train_req_in && !(ctrl_net_in && casc_pass_up_in)
      |=> tcs_out[0] == TCS_REQ_HIGH;
  endproperty
  a_high: assert property (p_high) else $error("high request not sent");
  property p_pass;
    rdy && ctrl_net_in && casc_pass_up_in && !casc_train_req_in && !casc_tx_off_in |=> tcs_out[0] == TCS_IDLE_UP;
  endproperty
  a_pass: assert property (p_pass) else $error("control hand-up not sent");
  property p_role;
    !(tcs_out[0] inside {TCS_IDLE_DOWN, TCS_INCOMING, TCS_GRANT, TCS_EN_HIGH, TCS_TRAIN_DOWN});
  endproperty
  a_role: assert property (p_role) else $error("local state on cascade");
  property p_rej;
    rdy && loc_cmd_valid_in[1] && loc_cmd_in[1] inside {TCS_IDLE_UP, TCS_REQ_HIGH, TCS_REQ_NORM, TCS_RETURN,
      TCS_TRAIN_UP} |=> cmd_reject_out[1];
  endproperty
  a_rej: assert property (p_rej) else $error("cascade state taken on local");
  property p_enh;
    rdy && loc_cmd_valid_in[1] && loc_cmd_in[1] == TCS_EN_HIGH |=> cmd_reject_out[1] != $past(lower_rep_in[1]);
  endproperty
  a_enh: assert property (p_enh) else $error("reclaim role check wrong");
  property p_frz;
    rdy && grant_state_in[2] |=> rcs_cur_out[2] == $past(rcs_cur_out[2]);
  endproperty
  a_frz: assert property (p_frz) else $error("receive state not held");
  property p_cyc;
    rdy && $rose(grant_state_in[0]) && !ctrl_net_in && tcs_out[0] inside {TCS_REQ_HIGH, TCS_REQ_NORM}
      |-> ##2 cycle_grant_out;
  endproperty
  a_cyc: assert property (p_cyc) else $error("cycle grant missing");
endmodule : rpc_asserts
bind repeater_port_control_states rpc_asserts #(.N(NUM_LOCAL_PORTS)) chk_u (
  .core_clk_in, .reset_n_in, .ctrl_net_in, .casc_pass_up_in, .casc_high_pend_in, .casc_train_req_in,
  .casc_tx_off_in, .loc_cmd_valid_in, .loc_cmd_in, .lower_rep_in, .grant_state_in, .tcs_out,
  .cmd_reject_out, .rcs_cur_out, .cycle_grant_out
);
`default_nettype wire

// ### verif/phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module phy_model #(
  parameter int N = 3
) (
  input  wire logic                core_clk_in,
  input  wire logic                reset_n_in,
  input  wire logic [N:0][10:0]    tcs_in,
  input  wire rpc_pkg::rcs_t [N:0] want_rcs_in,
  input  wire logic [N:0]          want_gs_in,
  input  wire logic [N:0]          auto_en_in,
  input  wire logic [3:0]          dly_in,
  output var rpc_pkg::rcs_t [N:0]  rcs_out,
  output logic [N:0]               gs_out
);
  import rpc_pkg::*;
  logic [4:0] cnt_q [N:0];
  // same-clock link side, one register stage
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    for (int p = 0; p <= N; p++) begin
      if (!reset_n_in) begin
        cnt_q[p] <= 5'h00;
        rcs_out[p] <= RCS_IDLE_UP;
        gs_out[p] <= 1'b0;
      end else begin
        // granted end node: wait, send one packet, then idle
        if (auto_en_in[p] && tcs_in[p] == TCS_GRANT) cnt_q[p] <= (cnt_q[p] == 5'h1f) ? cnt_q[p] : cnt_q[p] + 5'h01;
        else cnt_q[p] <= 5'h00;
        if (cnt_q[p] > 5'(dly_in) && cnt_q[p] <= 5'(dly_in) + 5'h04) rcs_out[p] <= RCS_DATA;
        else rcs_out[p] <= want_rcs_in[p];
        gs_out[p] <= want_gs_in[p];
      end
    end
  end
endmodule : phy_model
`default_nettype wire

// ### verif/test_repeater_port_control_states.sv
`timescale 1ns/1ps
`default_nettype none
module test_repeater_port_control_states;
  import rpc_pkg::*;
  localparam int N = 3;
  typedef struct {int p; logic rj; logic [10:0] t;} note_t;
  logic clk, rst_n, ctrl, pass, hp, np, intr, tr, txo, pu, ui, uin, ueh, uto, cg, cyg;
  logic [N:0] vld, lowr, agn, wgs, gs, upd, rej, rh, rn, ret, cb, used, dol, lw, mt, nt, cu, trq;
  logic [3:0] dly;
  logic [N:0][10:0] tcs;
  logic [N:0][3:0] rcur;
  tcs_t [N:0] cmd;
  rcs_t [N:0] wrcs, rcs;
  logic [10:0] et [N:0];
  logic [6:0] cv [7] = '{7'h40, 7'h20, 7'h18, 7'h04, 7'h03, 7'h13, 7'h00};
  tcs_t ce [7] = '{TCS_TX_OFF, TCS_TRAIN_UP, TCS_IDLE_UP, TCS_REQ_HIGH, TCS_RETURN, TCS_REQ_NORM, TCS_IDLE_UP};
  rcs_t ur [5] = '{RCS_IDLE_DOWN, RCS_INCOMING, RCS_EN_HIGH, RCS_TRAIN_DOWN, RCS_REQ_HIGH};
  logic [3:0] ue [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0};
  rcs_t lr [5] = '{RCS_DATA, RCS_LINK_WARN, RCS_MODE_TRANS, RCS_TRAIN_UP, RCS_IDLE_UP};
  logic [5:0] le [5] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h03};
  note_t q [$];
  int err_count, n_checks, c_used, c_ret, c_back, c_cyc, c_cont;

  repeater_port_control_states #(.NUM_LOCAL_PORTS(N)) dut_u (
    .core_clk_in(clk), .reset_n_in(rst_n), .ctrl_net_in(ctrl), .casc_pass_up_in(pass),
    .casc_high_pend_in(hp), .casc_norm_pend_in(np), .casc_interrupted_in(intr), .casc_train_req_in(tr),
    .casc_tx_off_in(txo), .loc_cmd_valid_in(vld), .loc_cmd_in(cmd), .lower_rep_in(lowr), .rcs_in(rcs),
    .grant_state_in(gs), .tcs_out(tcs), .tcs_upd_out(upd), .cmd_reject_out(rej), .rcs_cur_out(rcur),
    .data_on_link_out(dol), .link_warn_out(lw), .mode_trans_out(mt), .req_high_out(rh), .req_norm_out(rn),
    .no_traffic_out(nt), .ctl_up_out(cu), .return_out(ret), .ctl_back_out(cb), .train_req_out(trq),
    .grant_used_out(used), .pass_up_out(pu), .up_idle_out(ui), .up_incoming_out(uin),
    .up_en_high_out(ueh), .up_train_ok_out(uto), .cont_grant_out(cg), .cycle_grant_out(cyg)
  );
  phy_model #(.N(N)) phy_u (
    .core_clk_in(clk), .reset_n_in(rst_n), .tcs_in(tcs), .want_rcs_in(wrcs), .want_gs_in(wgs),
    .auto_en_in(agn), .dly_in(dly), .rcs_out(rcs), .gs_out(gs)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask : cy

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // the legality model is ours, kept apart from the design's own
  task automatic lcmd(input int p, input tcs_t c);
    logic ok;
    ok = ($countones(c) == 1) && !(c inside {TCS_IDLE_UP, TCS_REQ_HIGH, TCS_REQ_NORM, TCS_RETURN, TCS_TRAIN_UP})
         && (c != TCS_EN_HIGH || lowr[p] === 1'b1);
    @(posedge clk);
    vld[p] <= 1'b1;
    cmd[p] <= c;
    if (ok) et[p] = c;
    q.push_back('{p, !ok, et[p]});
    @(posedge clk);
    vld[p] <= 1'b0;
  endtask : lcmd

  initial begin
    note_t n;
    forever begin
      @(posedge clk);
      #1;
      c_used += int'(used[1]);
      c_ret += int'(ret[2]);
      c_back += int'(cb[2]);
      c_cyc += int'(cyg);
      c_cont += int'(cg);
      for (int p = 0; p <= N; p++) begin
        if (upd[p] === 1'b1 || rej[p] === 1'b1) begin
          if (q.size() == 0) chk("unexpected update", 0, 1);
          else begin
            n = q.pop_front();
            chk("port", n.p, p);
            chk("reject", n.rj, rej[p]);
            chk("tcs", n.t, tcs[p]);
          end
        end
      end
    end
  end

  initial begin
    int p;
    int b;
    for (int i = 0; i <= N; i++) begin
      cmd[i] = TCS_IDLE_DOWN;
      wrcs[i] = RCS_IDLE_UP;
      et[i] = (i == 0) ? TCS_IDLE_UP : TCS_IDLE_DOWN;
    end
    {rst_n, ctrl, pass, hp, np, intr, tr, txo} = 8'h00;
    vld = '0;
    lowr = 4'h4;
    agn = '0;
    wgs = '0;
    dly = 4'h0;
    void'($urandom(94397));
    cy(10);
    rst_n <= 1'b1;
    cy(4);
    chk("casc reset", TCS_IDLE_UP, tcs[0]);
    chk("local reset", TCS_IDLE_DOWN, tcs[3]);
    fin("reset");
    for (int i = 0; i < 7; i++) begin
      {txo, tr, ctrl, pass, hp, np, intr} <= cv[i];
      q.push_back('{0, 1'b0, ce[i]});
      cy(3);
      if (i == 2) chk("pass up", 1, pu);
    end
    hp <= 1'b1;
    q.push_back('{0, 1'b0, TCS_REQ_HIGH});
    cy(3);
    wgs[0] <= 1'b1;
    cy(4);
    wgs[0] <= 1'b0;
    ctrl <= 1'b1;
    cy(3);
    wgs[0] <= 1'b1;
    cy(4);
    {wgs[0], hp, ctrl} <= 3'h0;
    q.push_back('{0, 1'b0, TCS_IDLE_UP});
    cy(3);
    chk("cycle grant", 1, c_cyc);
    chk("cont grant", 1, c_cont);
    fin("cascade");
    for (p = 1; p <= 2; p++)
      for (b = 0; b < 11; b++) lcmd(p, tcs_t'(11'h001 << b));
    lcmd(1, tcs_t'(11'h003));
    agn[1] <= 1'b1;
    for (b = 0; b < 2; b++) begin
      dly <= 4'(b * 5);
      lcmd(1, TCS_GRANT);
      q.push_back('{1, 1'b0, TCS_IDLE_DOWN});
      et[1] = TCS_IDLE_DOWN;
      cy(20);
    end
    chk("one packet", 2, c_used);
    fin("local");
    agn <= '0;
    wrcs[2] <= RCS_REQ_HIGH;
    cy(4);
    chk("req high", 1, rh[2]);
    wrcs[2] <= RCS_REQ_NORM;
    wgs[2] <= 1'b1;
    cy(4);
    chk("held rcs", RCS_REQ_HIGH, rcur[2]);
    chk("return", 1, c_ret);
    wgs[2] <= 1'b0;
    cy(4);
    chk("req norm", 1, rn[2]);
    lcmd(2, TCS_EN_HIGH);
    ctrl <= 1'b1;
    cy(2);
    wgs[2] <= 1'b1;
    cy(4);
    chk("control back", 1, c_back);
    {wgs[2], ctrl} <= 2'h0;
    for (int i = 0; i < 5; i++) begin
      wrcs[0] <= ur[i];
      cy(4);
      chk("upper state", ue[i], {ui, uin, ueh, uto});
    end
    lcmd(2, TCS_GRANT);
    for (int i = 0; i < 5; i++) begin
      wrcs[2] <= lr[i];
      cy(4);
      chk("link state", le[i], {dol[2], lw[2], mt[2], trq[2], nt[2], cu[2]});
    end
    fin("receive");
    for (int i = 0; i < 40; i++) begin
      lowr[3:1] <= 3'($urandom);
      cy(1);
      p = 1 + int'($urandom % 3);
      b = int'($urandom % 12);
      lcmd(p, tcs_t'((b == 11) ? 11'h005 : 11'h001 << b));
    end
    for (int i = 0; i < 20 && q.size() > 0; i++) cy(1);
    chk("notes left", 0, q.size());
    fin("random");
    close_out();
  end
endmodule : test_repeater_port_control_states
`default_nettype wire
